// ### shared/gpio_pkg.sv
/*
 * Package for the 16-bit general-purpose I/O port: register offsets,
 * masked-array windows, reset values and the register request carrier.
 * Assumes byte addresses on a 12-bit register port with 32-bit data words.
 */
package gpio_pkg;

	localparam int PIN_W = 16;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;

	// register byte offsets
	localparam logic [11:0] DATA_OFS = 12'h000;
	localparam logic [11:0] OUTPUT_VALUE_OFS = 12'h004;
	localparam logic [11:0] DIR_SET_OFS = 12'h010;
	localparam logic [11:0] DIR_CLEAR_OFS = 12'h014;
	localparam logic [11:0] PIN_FUNCTION_SET_OFS = 12'h018;
	localparam logic [11:0] PIN_FUNCTION_CLEAR_OFS = 12'h01C;
	localparam logic [11:0] IRQ_ENABLE_SET_OFS = 12'h020;
	localparam logic [11:0] IRQ_ENABLE_CLEAR_OFS = 12'h024;
	localparam logic [11:0] IRQ_TYPE_SET_OFS = 12'h028;
	localparam logic [11:0] IRQ_TYPE_CLEAR_OFS = 12'h02C;
	localparam logic [11:0] IRQ_POL_SET_OFS = 12'h030;
	localparam logic [11:0] IRQ_POL_CLEAR_OFS = 12'h034;
	localparam logic [11:0] IRQ_STATUS_OFS = 12'h038;

	// masked arrays: addr[11:10] selects the array, addr[9:2] is the mask
	localparam logic [1:0] LOW_BYTE_ARRAY_SEL = 2'h1;
	localparam logic [1:0] HIGH_BYTE_ARRAY_SEL = 2'h2;
	localparam int ARRAY_SEL_LSB = 10;
	localparam int MASK_LSB = 2;
	localparam int MASK_W = 8;

	// build-time defaults
	localparam logic [15:0] ALTFN_CAPABLE_DEFAULT = 16'hFFFF;
	localparam logic [15:0] ALTFN_RESET_DEFAULT = 16'h0000;
	localparam logic BIG_ENDIAN_DEFAULT = 1'h0;
	localparam logic [15:0] CTRL_RESET = 16'h0000;
	localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

	// irq latency from pin to status, in core_clk cycles
	localparam int IRQ_LATENCY = 3;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [11:0] addr;
		logic [31:0] wdata;
	} reg_req_t;

endpackage : gpio_pkg

// ### design/pin_sync.sv
/*
 * Two-stage synchroniser for the sixteen port pins.
 * Assumes pins are asynchronous to core_clk; runs on the free-running clock.
 */
`timescale 1ns/1ps

module pin_sync (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic [15:0] pin_in,
	output logic [15:0] pin_sync_out
);

	genvar i;
	generate
		for (i = 0; i < gpio_pkg::PIN_W; i++) begin : g_bit
			// bit 0 catches the pin, bit 1 is the only reader of bit 0
			logic [1:0] chain_ff;
			logic [1:0] nxt_chain;
			always_comb begin
				nxt_chain = {chain_ff[0], pin_in[i]};
			end
			always_ff @(posedge core_clk or negedge reset_n) begin
				if (!reset_n) begin
					chain_ff <= 2'h0;
				end else begin
					chain_ff <= nxt_chain;
				end
			end
			assign pin_sync_out[i] = chain_ff[1];
		end
	endgenerate

endmodule : pin_sync

// ### design/gpio_port.sv
/*
 * Sixteen-pin general-purpose I/O port with set/clear control registers,
 * byte-wise masked access and per-pin level or edge interrupts.
 * Assumes a simple register port on core_clk; bus_clk_en stands for the
 * gateable bus clock, while pin sampling and irq detection run every cycle.
 */
`timescale 1ns/1ps

module gpio_port #(
	parameter logic [15:0] altfn_capable_mask = gpio_pkg::ALTFN_CAPABLE_DEFAULT,
	parameter logic [15:0] altfn_reset_value = gpio_pkg::ALTFN_RESET_DEFAULT,
	parameter logic big_endian = gpio_pkg::BIG_ENDIAN_DEFAULT
) (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic bus_clk_en,
	input wire gpio_pkg::reg_req_t reg_req,
	output logic [31:0] reg_rdata,
	input wire logic [15:0] port_in,
	output logic [15:0] port_out,
	output logic [15:0] port_oe,
	output logic [15:0] port_altfn,
	output logic [15:0] per_pin_irq,
	output logic combined_irq
);

	////////////////////////////////////////////////////////////////////////////
	// request decode

	logic [15:0] sync_in;
	logic [31:0] wdata_le;
	logic [15:0] wd;
	logic wr_en;
	logic rd_en;
	logic [1:0] array_sel;
	logic [7:0] mask;
	logic [15:0] low_mask16;
	logic [15:0] high_mask16;

	function automatic logic [31:0] swap_bytes(input logic [31:0] w);
		swap_bytes = {w[7:0], w[15:8], w[23:16], w[31:24]};
	endfunction : swap_bytes

	pin_sync u_pin_sync (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.pin_in(port_in),
		.pin_sync_out(sync_in)
	);

	always_comb begin
		wdata_le = big_endian ? swap_bytes(reg_req.wdata) : reg_req.wdata;
		wd = wdata_le[15:0];
		wr_en = reg_req.wr & bus_clk_en;
		rd_en = reg_req.rd & bus_clk_en;
		array_sel = reg_req.addr[gpio_pkg::ARRAY_SEL_LSB +: 2];
		mask = reg_req.addr[gpio_pkg::MASK_LSB +: gpio_pkg::MASK_W];
		low_mask16 = (array_sel == gpio_pkg::LOW_BYTE_ARRAY_SEL) ? {8'h00, mask} : 16'h0000;
		high_mask16 = (array_sel == gpio_pkg::HIGH_BYTE_ARRAY_SEL) ? {mask, 8'h00} : 16'h0000;
	end

	function automatic logic [15:0] wr_bits(input logic hit);
		wr_bits = (wr_en && hit) ? wd : 16'h0000;
	endfunction : wr_bits

	////////////////////////////////////////////////////////////////////////////
	// control registers

	logic [15:0] dout_ff, nxt_dout;
	logic [15:0] dir_ff, nxt_dir;
	logic [15:0] altfn_ff, nxt_altfn;
	logic [15:0] irq_en_ff, nxt_irq_en;
	logic [15:0] irq_type_ff, nxt_irq_type;
	logic [15:0] irq_pol_ff, nxt_irq_pol;
	logic [15:0] arr_mask;
	logic full_hit;

	always_comb begin
		full_hit = (reg_req.addr == gpio_pkg::DATA_OFS) || (reg_req.addr == gpio_pkg::OUTPUT_VALUE_OFS);
		arr_mask = wr_en ? (low_mask16 | high_mask16) : 16'h0000;
		nxt_dout = (dout_ff & ~arr_mask) | (wd & arr_mask);
		if (wr_en && full_hit) begin
			nxt_dout = wd;
		end
		nxt_dir = (dir_ff | wr_bits(reg_req.addr == gpio_pkg::DIR_SET_OFS))
			& ~wr_bits(reg_req.addr == gpio_pkg::DIR_CLEAR_OFS);
		nxt_altfn = ((altfn_ff | wr_bits(reg_req.addr == gpio_pkg::PIN_FUNCTION_SET_OFS))
			& ~wr_bits(reg_req.addr == gpio_pkg::PIN_FUNCTION_CLEAR_OFS)) & altfn_capable_mask;
		nxt_irq_en = (irq_en_ff | wr_bits(reg_req.addr == gpio_pkg::IRQ_ENABLE_SET_OFS))
			& ~wr_bits(reg_req.addr == gpio_pkg::IRQ_ENABLE_CLEAR_OFS);
		nxt_irq_type = (irq_type_ff | wr_bits(reg_req.addr == gpio_pkg::IRQ_TYPE_SET_OFS))
			& ~wr_bits(reg_req.addr == gpio_pkg::IRQ_TYPE_CLEAR_OFS);
		nxt_irq_pol = (irq_pol_ff | wr_bits(reg_req.addr == gpio_pkg::IRQ_POL_SET_OFS))
			& ~wr_bits(reg_req.addr == gpio_pkg::IRQ_POL_CLEAR_OFS);
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			dout_ff <= gpio_pkg::CTRL_RESET;
			dir_ff <= gpio_pkg::CTRL_RESET;
			altfn_ff <= altfn_reset_value & altfn_capable_mask;
			irq_en_ff <= gpio_pkg::CTRL_RESET;
			irq_type_ff <= gpio_pkg::CTRL_RESET;
			irq_pol_ff <= gpio_pkg::CTRL_RESET;
		end else begin
			dout_ff <= nxt_dout;
			dir_ff <= nxt_dir;
			altfn_ff <= nxt_altfn;
			irq_en_ff <= nxt_irq_en;
			irq_type_ff <= nxt_irq_type;
			irq_pol_ff <= nxt_irq_pol;
		end
	end

	assign port_out = dout_ff;
	assign port_oe = dir_ff;
	assign port_altfn = altfn_ff;

	////////////////////////////////////////////////////////////////////////////
	// interrupt detection, free-running

	logic [15:0] last_in_ff, nxt_last_in;
	logic [15:0] irq_status_ff, nxt_irq_status;
	logic [15:0] irq_event;
	logic [15:0] irq_clear;

	always_comb begin
		nxt_last_in = sync_in;
		// active level: pol 1 high, pol 0 low; edge: level now, not before
		irq_event = irq_en_ff & ~(sync_in ^ irq_pol_ff)
			& (~irq_type_ff | (last_in_ff ^ sync_in));
		irq_clear = wr_bits(reg_req.addr == gpio_pkg::IRQ_STATUS_OFS);
		nxt_irq_status = (irq_status_ff & ~irq_clear) | irq_event;
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			last_in_ff <= gpio_pkg::CTRL_RESET;
			irq_status_ff <= gpio_pkg::CTRL_RESET;
		end else begin
			last_in_ff <= nxt_last_in;
			irq_status_ff <= nxt_irq_status;
		end
	end

	assign per_pin_irq = irq_status_ff;
	assign combined_irq = |irq_status_ff;

	////////////////////////////////////////////////////////////////////////////
	// read data

	logic [31:0] rdata_ff, nxt_rdata;
	logic [15:0] rd_val;

	always_comb begin
		rd_val = 16'h0000;
		if (array_sel == gpio_pkg::LOW_BYTE_ARRAY_SEL || array_sel == gpio_pkg::HIGH_BYTE_ARRAY_SEL) begin
			rd_val = sync_in & (low_mask16 | high_mask16);
		end else begin
			unique case (reg_req.addr)
				gpio_pkg::DATA_OFS: rd_val = sync_in;
				gpio_pkg::OUTPUT_VALUE_OFS: rd_val = dout_ff;
				gpio_pkg::DIR_SET_OFS, gpio_pkg::DIR_CLEAR_OFS: rd_val = dir_ff;
				gpio_pkg::PIN_FUNCTION_SET_OFS, gpio_pkg::PIN_FUNCTION_CLEAR_OFS: rd_val = altfn_ff;
				gpio_pkg::IRQ_ENABLE_SET_OFS, gpio_pkg::IRQ_ENABLE_CLEAR_OFS: rd_val = irq_en_ff;
				gpio_pkg::IRQ_TYPE_SET_OFS, gpio_pkg::IRQ_TYPE_CLEAR_OFS: rd_val = irq_type_ff;
				gpio_pkg::IRQ_POL_SET_OFS, gpio_pkg::IRQ_POL_CLEAR_OFS: rd_val = irq_pol_ff;
				gpio_pkg::IRQ_STATUS_OFS: rd_val = irq_status_ff;
				default: rd_val = 16'h0000;
			endcase
		end
		nxt_rdata = rdata_ff;
		if (rd_en) begin
			nxt_rdata = big_endian ? swap_bytes({16'h0000, rd_val}) : {16'h0000, rd_val};
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rdata_ff <= gpio_pkg::RDATA_RESET;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	assign reg_rdata = rdata_ff;

	////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	status_set_a: assert property ((|irq_event) |=> ((per_pin_irq & $past(irq_event)) == $past(irq_event)))
		else $error("irq event did not set status");
	combined_or_a: assert property (combined_irq == (per_pin_irq != 16'h0000))
		else $error("combined irq disagrees with per-pin irq");
	irq_gate_a: assert property ((irq_event & ~irq_en_ff) == 16'h0000)
		else $error("event on disabled pin");
	edge_once_a: assert property ((irq_event & irq_type_ff & ~(sync_in ^ $past(sync_in))) == 16'h0000)
		else $error("edge irq fired without an edge");
	status_clear_a: assert property ((wr_en && reg_req.addr == gpio_pkg::IRQ_STATUS_OFS)
		|=> ((per_pin_irq & $past(wd) & ~$past(irq_event)) == 16'h0000))
		else $error("status bit not cleared");
	dir_set_a: assert property ((wr_en && reg_req.addr == gpio_pkg::DIR_SET_OFS)
		|=> ((port_oe & $past(wd)) == $past(wd)))
		else $error("direction set failed");
	dir_clear_a: assert property ((wr_en && reg_req.addr == gpio_pkg::DIR_CLEAR_OFS)
		|=> ((port_oe & $past(wd)) == 16'h0000))
		else $error("direction clear failed");
	altfn_mask_a: assert property ((port_altfn & ~altfn_capable_mask) == 16'h0000)
		else $error("alternate function on incapable pin");
	low_mask_a: assert property ((wr_en && array_sel == gpio_pkg::LOW_BYTE_ARRAY_SEL)
		|=> port_out == (($past(dout_ff) & ~{8'h00, $past(mask)}) | ($past(wd) & {8'h00, $past(mask)})))
		else $error("low byte masked write wrong");
	high_mask_a: assert property ((wr_en && array_sel == gpio_pkg::HIGH_BYTE_ARRAY_SEL)
		|=> port_out == (($past(dout_ff) & ~{$past(mask), 8'h00}) | ($past(wd) & {$past(mask), 8'h00})))
		else $error("high byte masked write wrong");
	dout_read_a: assert property ((rd_en && reg_req.addr == gpio_pkg::OUTPUT_VALUE_OFS && !big_endian)
		|=> reg_rdata == {16'h0000, $past(port_out)})
		else $error("output value readback wrong");
	gated_write_a: assert property ((!bus_clk_en) |=> $stable(port_oe) && $stable(port_out))
		else $error("register changed while bus clock stopped");
	altfn_set_a: assert property ((wr_en && reg_req.addr == gpio_pkg::PIN_FUNCTION_SET_OFS)
		|=> ((port_altfn & $past(wd & altfn_capable_mask)) == $past(wd & altfn_capable_mask)))
		else $error("function set failed");
	altfn_clear_a: assert property ((wr_en && reg_req.addr == gpio_pkg::PIN_FUNCTION_CLEAR_OFS)
		|=> ((port_altfn & $past(wd)) == 16'h0000))
		else $error("function clear failed");
	irq_en_set_a: assert property ((wr_en && reg_req.addr == gpio_pkg::IRQ_ENABLE_SET_OFS)
		|=> ((irq_en_ff & $past(wd)) == $past(wd)))
		else $error("irq enable set failed");
	irq_en_clear_a: assert property ((wr_en && reg_req.addr == gpio_pkg::IRQ_ENABLE_CLEAR_OFS)
		|=> ((irq_en_ff & $past(wd)) == 16'h0000))
		else $error("irq enable clear failed");
	irq_type_set_a: assert property ((wr_en && reg_req.addr == gpio_pkg::IRQ_TYPE_SET_OFS)
		|=> ((irq_type_ff & $past(wd)) == $past(wd)))
		else $error("irq type set failed");
	irq_type_clear_a: assert property ((wr_en && reg_req.addr == gpio_pkg::IRQ_TYPE_CLEAR_OFS)
		|=> ((irq_type_ff & $past(wd)) == 16'h0000))
		else $error("irq type clear failed");
	irq_pol_set_a: assert property ((wr_en && reg_req.addr == gpio_pkg::IRQ_POL_SET_OFS)
		|=> ((irq_pol_ff & $past(wd)) == $past(wd)))
		else $error("irq polarity set failed");
	irq_pol_clear_a: assert property ((wr_en && reg_req.addr == gpio_pkg::IRQ_POL_CLEAR_OFS)
		|=> ((irq_pol_ff & $past(wd)) == 16'h0000))
		else $error("irq polarity clear failed");
	full_write_a: assert property ((wr_en && reg_req.addr == gpio_pkg::OUTPUT_VALUE_OFS)
		|=> (port_out == $past(wd)))
		else $error("output value write failed");
	low_read_a: assert property ((rd_en && array_sel == gpio_pkg::LOW_BYTE_ARRAY_SEL && !big_endian)
		|=> ((reg_rdata & ~{24'h000000, $past(mask)}) == 32'h0000_0000))
		else $error("low byte masked read shows unmasked bits");
	high_read_a: assert property ((rd_en && array_sel == gpio_pkg::HIGH_BYTE_ARRAY_SEL && !big_endian)
		|=> ((reg_rdata & ~{16'h0000, $past(mask), 8'h00}) == 32'h0000_0000))
		else $error("high byte masked read shows unmasked bits");
	rdata_hold_a: assert property ((!rd_en) |=> $stable(reg_rdata))
		else $error("read data changed without a read");
	status_hold_a: assert property (((irq_event == 16'h0000) && !(wr_en && reg_req.addr == gpio_pkg::IRQ_STATUS_OFS))
		|=> $stable(per_pin_irq))
		else $error("status changed without event or clear");

	// per-pin latency and mode checks
	for (genvar k = 0; k < gpio_pkg::PIN_W; k++) begin : g_irq_chk
		rise_latency_a: assert property (@(posedge core_clk) disable iff (!reset_n)
			($rose(sync_in[k]) && irq_en_ff[k] && irq_type_ff[k] && irq_pol_ff[k]) |=> per_pin_irq[k])
			else $error("rising edge did not set status next cycle");
		fall_latency_a: assert property (@(posedge core_clk) disable iff (!reset_n)
			($fell(sync_in[k]) && irq_en_ff[k] && irq_type_ff[k] && !irq_pol_ff[k]) |=> per_pin_irq[k])
			else $error("falling edge did not set status next cycle");
		level_set_a: assert property (@(posedge core_clk) disable iff (!reset_n)
			(irq_en_ff[k] && !irq_type_ff[k] && (sync_in[k] == irq_pol_ff[k])) |=> per_pin_irq[k])
			else $error("active level did not set status");
	end

	edge_irq_c: cover property (irq_en_ff[0] && irq_type_ff[0] ##1 $rose(per_pin_irq[0]));
	level_irq_c: cover property (irq_en_ff[1] && !irq_type_ff[1] ##1 per_pin_irq[1] [*3]);
	masked_write_c: cover property (wr_en && array_sel == gpio_pkg::HIGH_BYTE_ARRAY_SEL && mask != 8'hFF);
	status_clear_c: cover property (per_pin_irq[0] ##1 !per_pin_irq[0]);
	gated_write_c: cover property (!bus_clk_en && reg_req.wr);

endmodule : gpio_port

// ### dv/pin_model.sv
/*
 * Pin-side partner: drives the sixteen port pins off the clock grid.
 * Assumes the bench sets target levels just after a core_clk edge.
 */
`timescale 1ns/1ps

module pin_model (
	input wire logic [15:0] pin_target,
	output logic [15:0] pin_level
);
	// skewed so pin changes never line up with a sampling edge
	// runs first at time zero so the pins take a known level 0.7 ns after start
	always begin
		pin_level <= #0.7 pin_target;
		@(pin_target);
	end
endmodule : pin_model

// ### dv/gpio_port_tb.sv
/*
 * Self-checking bench for the 16-pin port: registers, masked access, irq modes.
 * Assumes pin_model on the pins and one-cycle register strobes on core_clk.
 */
`timescale 1ns/1ps

module gpio_port_tb;
	localparam logic [15:0] CAP = 16'hF0FF;
	localparam logic [15:0] ALT0 = 16'h0101;
	logic core_clk = 1'b0;
	logic reset_n = 1'b0;
	logic bus_clk_en = 1'b1;
	gpio_pkg::reg_req_t reg_req = '0;
	logic [31:0] reg_rdata;
	logic [15:0] pin_target = 16'h0000;
	logic [15:0] port_in, port_out, port_oe, port_altfn, per_pin_irq;
	logic combined_irq;
	logic [31:0] be_rdata;
	logic [15:0] be_port_out;
	logic [31:0] exp_q[$];
	int bad_count = 0;
	int num_checks = 0;
	logic [15:0] d, m, bt;
	logic [7:0] mh, rh;
	logic pol;
	int p, i;

	always #2.5 core_clk = ~core_clk;

	gpio_port #(.altfn_capable_mask(CAP), .altfn_reset_value(ALT0), .big_endian(1'h0)) u_gpio_port (
		.core_clk(core_clk), .reset_n(reset_n), .bus_clk_en(bus_clk_en), .reg_req(reg_req),
		.reg_rdata(reg_rdata), .port_in(port_in), .port_out(port_out), .port_oe(port_oe),
		.port_altfn(port_altfn), .per_pin_irq(per_pin_irq), .combined_irq(combined_irq));
	gpio_port #(.altfn_capable_mask(CAP), .altfn_reset_value(ALT0), .big_endian(1'h1)) u_gpio_port_be (
		.core_clk(core_clk), .reset_n(reset_n), .bus_clk_en(bus_clk_en), .reg_req(reg_req),
		.reg_rdata(be_rdata), .port_in(port_in), .port_out(be_port_out), .port_oe(),
		.port_altfn(), .per_pin_irq(), .combined_irq());
	pin_model u_pin_model (.pin_target(pin_target), .pin_level(port_in));

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", what, e, g);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : cyc

	task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] v);
		cyc(1);
		reg_req.wr = w;
		reg_req.rd = !w;
		reg_req.addr = a;
		reg_req.wdata = w ? v : 32'h0000_0000;
		if (!w) begin
			exp_q.push_back(v);
		end
		cyc(1);
		reg_req.wr = 1'b0;
		reg_req.rd = 1'b0;
	endtask : acc

	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : final_report

	// read results: oldest note against the data 2 ns after the edge that takes a read
	always @(posedge core_clk) begin
		if (reset_n && bus_clk_en && reg_req.rd && exp_q.size() > 0) begin
			#2;
			chk("reg_rdata", exp_q.pop_front(), reg_rdata);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(32'h9fb8));
		cyc(10);
		reset_n = 1'b1;
		chk("port_out", 32'h0, {16'h0, port_out});
		chk("port_oe", 32'h0, {16'h0, port_oe});
		chk("port_altfn", {16'h0, ALT0 & CAP}, {16'h0, port_altfn});
		chk("combined_irq", 32'h0, {31'h0, combined_irq});
		acc(1'b0, gpio_pkg::OUTPUT_VALUE_OFS, 32'h0);
		$display("test reset values done");

		d = 16'($urandom());
		acc(1'b1, gpio_pkg::OUTPUT_VALUE_OFS, {16'h0, d});
		chk("port_out", {16'h0, d}, {16'h0, port_out});
		acc(1'b0, gpio_pkg::OUTPUT_VALUE_OFS, {16'h0, d});
		acc(1'b1, gpio_pkg::DIR_SET_OFS, 32'h00F3);
		acc(1'b1, gpio_pkg::DIR_SET_OFS, 32'h0000);
		acc(1'b1, gpio_pkg::DIR_CLEAR_OFS, 32'h0003);
		acc(1'b0, gpio_pkg::DIR_SET_OFS, 32'h00F0);
		acc(1'b0, gpio_pkg::DIR_CLEAR_OFS, 32'h00F0);
		chk("port_oe", 32'h00F0, {16'h0, port_oe});
		acc(1'b1, gpio_pkg::PIN_FUNCTION_SET_OFS, 32'hFFFF);
		acc(1'b0, gpio_pkg::PIN_FUNCTION_SET_OFS, {16'h0, CAP});
		acc(1'b1, gpio_pkg::PIN_FUNCTION_CLEAR_OFS, 32'h0011);
		acc(1'b0, gpio_pkg::PIN_FUNCTION_CLEAR_OFS, {16'h0, CAP & 16'hFFEE});
		chk("port_altfn", {16'h0, CAP & 16'hFFEE}, {16'h0, port_altfn});
		bus_clk_en = 1'b0;
		acc(1'b1, gpio_pkg::OUTPUT_VALUE_OFS, {16'h0, ~d});
		bus_clk_en = 1'b1;
		acc(1'b0, gpio_pkg::OUTPUT_VALUE_OFS, {16'h0, d});
		$display("test control registers done");

		acc(1'b1, {2'h1, 8'hC3, 2'h0}, 32'h0003);
		d = (d & 16'hFF3C) | 16'h0003;
		chk("port_out", {16'h0, d}, {16'h0, port_out});
		mh = 8'($urandom());
		rh = 8'($urandom());
		acc(1'b1, {2'h2, mh, 2'h0}, {16'h0, rh, 8'h00});
		d = (d & ~{mh, 8'h00}) | ({rh, 8'h00} & {mh, 8'h00});
		chk("port_out", {16'h0, d}, {16'h0, port_out});
		pin_target = 16'($urandom());
		cyc(3);
		acc(1'b0, {2'h1, 8'hA5, 2'h2}, {16'h0, pin_target & 16'h00A5});
		acc(1'b0, {2'h2, 8'hFF, 2'h0}, {16'h0, pin_target & 16'hFF00});
		acc(1'b0, gpio_pkg::DATA_OFS, {16'h0, pin_target});
		$display("test masked access done");

		p = $urandom_range(15, 0);
		bt = 16'h0001 << p;
		for (i = 0; i < 4; i++) begin
			pol = i[1];
			pin_target = pol ? 16'h0000 : 16'hFFFF;
			acc(1'b1, pol ? gpio_pkg::IRQ_POL_SET_OFS : gpio_pkg::IRQ_POL_CLEAR_OFS, {16'h0, bt});
			acc(1'b1, i[0] ? gpio_pkg::IRQ_TYPE_SET_OFS : gpio_pkg::IRQ_TYPE_CLEAR_OFS, {16'h0, bt});
			acc(1'b1, gpio_pkg::IRQ_STATUS_OFS, 32'hFFFF);
			acc(1'b1, gpio_pkg::IRQ_ENABLE_SET_OFS, {16'h0, bt});
			chk("per_pin_irq idle", 32'h0, {16'h0, per_pin_irq});
			pin_target[p] = pol;
			cyc(2);
			chk("per_pin_irq early", 32'h0, {16'h0, per_pin_irq});
			cyc(1);
			chk("per_pin_irq", {16'h0, bt}, {16'h0, per_pin_irq});
			chk("combined_irq", 32'h1, {31'h0, combined_irq});
			acc(1'b0, gpio_pkg::IRQ_STATUS_OFS, {16'h0, bt});
			acc(1'b1, gpio_pkg::IRQ_STATUS_OFS, {16'h0, bt});
			cyc(2);
			chk("per_pin_irq held", {16'h0, i[0] ? 16'h0 : bt}, {16'h0, per_pin_irq});
			pin_target[p] = !pol;
			cyc(4);
			acc(1'b1, gpio_pkg::IRQ_STATUS_OFS, {16'h0, bt});
			cyc(1);
			chk("per_pin_irq cleared", 32'h0, {16'h0, per_pin_irq});
			chk("combined_irq", 32'h0, {31'h0, combined_irq});
			acc(1'b1, gpio_pkg::IRQ_ENABLE_CLEAR_OFS, {16'h0, bt});
			pin_target[p] = pol;
			cyc(4);
			chk("per_pin_irq disabled", 32'h0, {16'h0, per_pin_irq});
			pin_target[p] = !pol;
			cyc(4);
			$display("test irq mode %0d done", i);
		end

		// same word seen little-endian by one port and big-endian by the other
		acc(1'b1, gpio_pkg::OUTPUT_VALUE_OFS, {d[7:0], d[15:8], 16'h0000});
		chk("port_out", 32'h0, {16'h0, port_out});
		chk("be port_out", {16'h0, d}, {16'h0, be_port_out});
		acc(1'b0, gpio_pkg::OUTPUT_VALUE_OFS, 32'h0);
		chk("be reg_rdata", {d[7:0], d[15:8], 16'h0000}, be_rdata);
		$display("test byte order done");

		for (i = 0; i < 20 && exp_q.size() > 0; i++) begin
			cyc(1);
		end
		if (exp_q.size() > 0) begin
			bad_count++;
			$display("mismatch read queue expected %0d seen %0d", 0, exp_q.size());
		end
		final_report();
	end
endmodule : gpio_port_tb
